// ---- rtl/tcs_ctrl.sv ----
// Top of the trim, calibration and video self-test control block with Avalon-MM slave.
// Assumes a video timing generator, and a downstream link that carries trim requests.
`timescale 1ns/1ns
// Operation
// - Read-only bit 15 reports automatic trimming has completed.
// - Read-only bit 14 reports trimming success, valid when bit 15 is one.
// - Bit 13 sets when calibration finishes and clears when software reads it.
// - Select bit picks calibration byte 8'h55 when zero, 8'haa when one.
// - Writing calibration start runs calibration, then self-clears and raises bit 13.
// - While calibrating, bits 3:0 act as the calibration filter setting.
// - Run bit starts patterns; clearing stops only at the next frame boundary.
// - Enabled self-test repeats red, green, blue, black, white frames.
// - Writing trim enable runs trimming, then self-clears and updates bits 15, 14.
// - Trim read request header upper nibble comes from bits 7:4.
// - Trim read request header lower nibble comes from bits 3:0.
module tcs_ctrl #(
   parameter int TRIM_TIMEOUT = tcs_pkg::TCS_TRIM_TIMEOUT_CYC
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Avalon-MM slave.
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Video timing and self-test output.
   input wire tcs_pkg::tcs_timing_t timing,
   output logic vst_active,
   output logic [2:0] vst_colour,
   // Downstream trimming link.
   output tcs_pkg::tcs_trim_req_t trim_req,
   input wire tcs_pkg::tcs_trim_rsp_t trim_rsp,
   // Calibration observation.
   output logic [7:0] cal_result,
   // Interrupt.
   output logic irq
);
   logic [15:0] reg_q, reg_d;
   logic [2:0] ist_q, ist_d;
   logic [2:0] imask_q, imask_d;
   logic [31:0] rdata_q, rdata_d;
   logic ack_q, ack_d;
   logic wreq_q, wreq_d;
   logic irq_q, irq_d;
   tcs_pkg::tcs_trim_state_t tst_q, tst_d;
   tcs_pkg::tcs_trim_req_t req_q, req_d;
   logic [7:0] tmo_q, tmo_d;
   logic cal_start_pulse;
   logic cal_done;
   logic [7:0] cal_res;
   logic [7:0] cal_byte;
   logic vst_act;
   tcs_pkg::tcs_colour_t vst_col;
   logic wr_acc, rd_acc;
   logic trim_fin, trim_ok;
   logic [15:0] wval;

   assign wr_acc = avs_write && !ack_q;
   assign rd_acc = avs_read && !ack_q;
   assign wval = {avs_byteenable[1] ? avs_writedata[15:8] : reg_q[15:8],
                  avs_byteenable[0] ? avs_writedata[7:0] : reg_q[7:0]};
   assign cal_start_pulse = wr_acc && (avs_address == tcs_pkg::TCS_OFS_TUNING)
                            && wval[tcs_pkg::TCS_BIT_CAL_START]
                            && !reg_q[tcs_pkg::TCS_BIT_CAL_START];
   assign cal_byte = reg_q[tcs_pkg::TCS_BIT_CAL_SEL] ? tcs_pkg::TCS_CAL_BYTE_1
                     : tcs_pkg::TCS_CAL_BYTE_0;

   tcs_cal_engine u_cal (
      .ref_clk(ref_clk),
      .rst(rst),
      .start(cal_start_pulse),
      .cal_byte(cal_byte),
      .filter(reg_q[3:0]),
      .done(cal_done),
      .xor_result(cal_res)
   );

   tcs_vst_engine u_vst (
      .ref_clk(ref_clk),
      .rst(rst),
      .enable(reg_q[tcs_pkg::TCS_BIT_VST_EN]),
      .run(reg_q[tcs_pkg::TCS_BIT_VST_RUN]),
      .frame_start(timing.frame_start),
      .active(vst_act),
      .colour(vst_col)
   );

   // Trimming sequencer: one read request, then wait for the answer or a timeout.
   always_comb begin
      tst_d = tst_q;
      req_d = req_q;
      tmo_d = tmo_q;
      trim_fin = 1'b0;
      trim_ok = 1'b0;
      req_d.valid = 1'b0;
      case (tst_q)
         tcs_pkg::TCS_TR_IDLE: begin
            if (reg_q[tcs_pkg::TCS_BIT_TRIM_EN]) begin
               tst_d = tcs_pkg::TCS_TR_SEND;
            end
         end
         tcs_pkg::TCS_TR_SEND: begin
            req_d.valid = 1'b1;
            req_d.header = reg_q[7:0];
            tmo_d = 8'(TRIM_TIMEOUT - 1);
            tst_d = tcs_pkg::TCS_TR_WAIT;
         end
         tcs_pkg::TCS_TR_WAIT: begin
            if (trim_rsp.valid) begin
               trim_fin = 1'b1;
               trim_ok = trim_rsp.pass;
               tst_d = tcs_pkg::TCS_TR_IDLE;
            end else if (tmo_q == 8'h00) begin
               // A silent receiver ends the trim as a failure rather than hanging.
               trim_fin = 1'b1;
               tst_d = tcs_pkg::TCS_TR_IDLE;
            end else begin
               tmo_d = tmo_q - 8'h01;
            end
         end
         default: begin
            tst_d = tcs_pkg::TCS_TR_IDLE;
         end
      endcase
   end

   // Register file, status events and bus answer.
   always_comb begin
      reg_d = reg_q;
      ist_d = ist_q;
      imask_d = imask_q;
      rdata_d = rdata_q;
      ack_d = 1'b0;
      wreq_d = 1'b1;
      if (wr_acc || rd_acc) begin
         ack_d = 1'b1;
         wreq_d = 1'b0;
      end
      if (wr_acc) begin
         if (avs_address == tcs_pkg::TCS_OFS_TUNING) begin
            reg_d = (reg_q & ~tcs_pkg::TCS_WRITE_MASK) | (wval & tcs_pkg::TCS_WRITE_MASK);
            if (reg_q[tcs_pkg::TCS_BIT_TRIM_EN]) begin
               reg_d[tcs_pkg::TCS_BIT_TRIM_EN] = 1'b1;
            end
            if (reg_q[tcs_pkg::TCS_BIT_CAL_START]) begin
               reg_d[tcs_pkg::TCS_BIT_CAL_START] = 1'b1;
            end
            if (wval[tcs_pkg::TCS_BIT_TRIM_EN] && !reg_q[tcs_pkg::TCS_BIT_TRIM_EN]) begin
               reg_d[tcs_pkg::TCS_BIT_TRIM_DONE] = 1'b0;
               reg_d[tcs_pkg::TCS_BIT_TRIM_PASS] = 1'b0;
            end
         end else if (avs_address == tcs_pkg::TCS_OFS_IRQ_MASK) begin
            if (avs_byteenable[0]) begin
               imask_d = avs_writedata[2:0];
            end
         end
      end
      if (rd_acc) begin
         if (avs_address == tcs_pkg::TCS_OFS_TUNING) begin
            rdata_d = {16'h0000, reg_q};
            reg_d[tcs_pkg::TCS_BIT_CAL_DONE] = 1'b0;
         end else if (avs_address == tcs_pkg::TCS_OFS_IRQ_STAT) begin
            rdata_d = {29'h0, ist_q};
            ist_d = 3'h0;
         end else if (avs_address == tcs_pkg::TCS_OFS_IRQ_MASK) begin
            rdata_d = {29'h0, imask_q};
         end else begin
            rdata_d = 32'h0000_0000;
         end
      end
      // Hardware events are applied last so a set beats a read clear in the same cycle.
      if (trim_fin) begin
         reg_d[tcs_pkg::TCS_BIT_TRIM_EN] = 1'b0;
         reg_d[tcs_pkg::TCS_BIT_TRIM_DONE] = 1'b1;
         reg_d[tcs_pkg::TCS_BIT_TRIM_PASS] = trim_ok;
         ist_d[0] = 1'b1;
      end
      if (cal_done) begin
         reg_d[tcs_pkg::TCS_BIT_CAL_START] = 1'b0;
         reg_d[tcs_pkg::TCS_BIT_CAL_DONE] = 1'b1;
         ist_d[1] = 1'b1;
      end
      if (timing.frame_start && vst_act) begin
         ist_d[2] = 1'b1;
      end
   end

   always_comb begin
      irq_d = |(ist_d & imask_d);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reg_q <= tcs_pkg::TCS_TUNING_RESET;
         ist_q <= 3'h0;
         imask_q <= 3'h0;
         rdata_q <= 32'h0000_0000;
         ack_q <= 1'b0;
         wreq_q <= 1'b1;
         irq_q <= 1'b0;
         tst_q <= tcs_pkg::TCS_TR_IDLE;
         req_q <= '0;
         tmo_q <= 8'h00;
         vst_active <= 1'b0;
         vst_colour <= 3'h0;
         cal_result <= 8'h00;
      end else begin
         reg_q <= reg_d;
         ist_q <= ist_d;
         imask_q <= imask_d;
         rdata_q <= rdata_d;
         ack_q <= ack_d;
         wreq_q <= wreq_d;
         irq_q <= irq_d;
         tst_q <= tst_d;
         req_q <= req_d;
         tmo_q <= tmo_d;
         vst_active <= vst_act && timing.de;
         vst_colour <= vst_col;
         cal_result <= cal_res;
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wreq_q;
   assign trim_req = req_q;
   assign irq = irq_q;

   // The checks below watch the register fields, the sequencer and the self-test engine.
   AST_TRIM_REQ_HEADER: assert property (@(posedge ref_clk) disable iff (rst)
      trim_req.valid |-> trim_req.header == $past(reg_q[7:0]))
      else $error("trim header not from register");
   AST_TRIM_ONE_SHOT: assert property (@(posedge ref_clk) disable iff (rst)
      trim_req.valid |=> !trim_req.valid)
      else $error("trim request longer than one cycle");
   AST_TRIM_FINISH: assert property (@(posedge ref_clk) disable iff (rst)
      (tst_q == tcs_pkg::TCS_TR_WAIT && trim_rsp.valid) |=>
      reg_q[tcs_pkg::TCS_BIT_TRIM_DONE] && !reg_q[tcs_pkg::TCS_BIT_TRIM_EN])
      else $error("trim enable did not self clear");
   AST_TRIM_PASS: assert property (@(posedge ref_clk) disable iff (rst)
      (tst_q == tcs_pkg::TCS_TR_WAIT && trim_rsp.valid) |=>
      reg_q[tcs_pkg::TCS_BIT_TRIM_PASS] == $past(trim_rsp.pass))
      else $error("trim pass flag wrong");
   AST_TRIM_DONE_SET: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(reg_q[tcs_pkg::TCS_BIT_TRIM_DONE]) |-> $past(tst_q == tcs_pkg::TCS_TR_WAIT))
      else $error("trim done set without trimming");
   AST_CAL_DONE: assert property (@(posedge ref_clk) disable iff (rst)
      cal_done |=> reg_q[tcs_pkg::TCS_BIT_CAL_DONE] && !reg_q[tcs_pkg::TCS_BIT_CAL_START])
      else $error("calibration completion not reflected");
   AST_CAL_CLEAR_READ: assert property (@(posedge ref_clk) disable iff (rst)
      (rd_acc && avs_address == tcs_pkg::TCS_OFS_TUNING && !cal_done) |=>
      !reg_q[tcs_pkg::TCS_BIT_CAL_DONE])
      else $error("calibration done not cleared by read");
   AST_RO_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
      (wr_acc && !trim_fin && !cal_done && !(wval[tcs_pkg::TCS_BIT_TRIM_EN]
       && !reg_q[tcs_pkg::TCS_BIT_TRIM_EN])) |=> $stable(reg_q[15:13]))
      else $error("write changed read-only flag");
   AST_VST_FRAME_STOP: assert property (@(posedge ref_clk) disable iff (rst)
      (vst_act && !timing.frame_start && reg_q[tcs_pkg::TCS_BIT_VST_EN]) |=> vst_act)
      else $error("self test stopped mid frame");
   AST_WAIT_ONE: assert property (@(posedge ref_clk) disable iff (rst)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   AST_CAL_BYTE_LOW: assert property (@(posedge ref_clk) disable iff (rst)
      !reg_q[tcs_pkg::TCS_BIT_CAL_SEL] |-> cal_byte == tcs_pkg::TCS_CAL_BYTE_0)
      else $error("calibration byte wrong for select zero");
   AST_CAL_BYTE_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
      reg_q[tcs_pkg::TCS_BIT_CAL_SEL] |-> cal_byte == tcs_pkg::TCS_CAL_BYTE_1)
      else $error("calibration byte wrong for select one");
   AST_CAL_BUSY_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
      cal_start_pulse |=> reg_q[tcs_pkg::TCS_BIT_CAL_START])
      else $error("calibration start bit not held while busy");
   AST_CAL_DONE_SRC: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(reg_q[tcs_pkg::TCS_BIT_CAL_DONE]) |-> $past(cal_done))
      else $error("calibration done set without calibration");
   AST_TRIM_START: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(reg_q[tcs_pkg::TCS_BIT_TRIM_EN]) |=> tst_q == tcs_pkg::TCS_TR_SEND)
      else $error("trim enable did not start the sequencer");
   AST_TRIM_TIMEOUT: assert property (@(posedge ref_clk) disable iff (rst)
      (tst_q == tcs_pkg::TCS_TR_WAIT && !trim_rsp.valid && tmo_q == 8'h00) |=>
      reg_q[tcs_pkg::TCS_BIT_TRIM_DONE] && !reg_q[tcs_pkg::TCS_BIT_TRIM_PASS])
      else $error("trim timeout not reported as failure");
   AST_TRIM_PASS_DONE: assert property (@(posedge ref_clk) disable iff (rst)
      reg_q[tcs_pkg::TCS_BIT_TRIM_PASS] |-> reg_q[tcs_pkg::TCS_BIT_TRIM_DONE])
      else $error("trim pass without trim done");
   AST_RESET_ZERO: assert property (@(posedge ref_clk)
      rst |=> reg_q == tcs_pkg::TCS_TUNING_RESET && ist_q == 3'h0 && !irq)
      else $error("reset did not clear the register");
   AST_VST_FRAME_START: assert property (@(posedge ref_clk) disable iff (rst)
      (timing.frame_start && reg_q[tcs_pkg::TCS_BIT_VST_EN]) |=>
      vst_act == $past(reg_q[tcs_pkg::TCS_BIT_VST_RUN]))
      else $error("self test run not applied at frame boundary");
   AST_VST_COLOUR_STEP: assert property (@(posedge ref_clk) disable iff (rst)
      (timing.frame_start && vst_act && reg_q[tcs_pkg::TCS_BIT_VST_EN]) |=>
      vst_col != $past(vst_col))
      else $error("self test colour did not advance");
   AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (rst)
      irq == |(ist_q & imask_q))
      else $error("interrupt level not matching status");
endmodule : tcs_ctrl

// ---- rtl/tcs_pkg.sv ----
// Package for the trim, calibration and video self-test control block.
// Assumes a single 20 MHz clock domain and a synchronous active-high reset.
package tcs_pkg;
   localparam logic [7:0] TCS_OFS_TUNING = 8'hee;
   localparam logic [7:0] TCS_OFS_IRQ_STAT = 8'hf0;
   localparam logic [7:0] TCS_OFS_IRQ_MASK = 8'hf4;
   localparam int TCS_BIT_TRIM_DONE = 15;
   localparam int TCS_BIT_TRIM_PASS = 14;
   localparam int TCS_BIT_CAL_DONE = 13;
   localparam int TCS_BIT_CAL_SEL = 12;
   localparam int TCS_BIT_CAL_START = 11;
   localparam int TCS_BIT_VST_RUN = 10;
   localparam int TCS_BIT_VST_EN = 9;
   localparam int TCS_BIT_TRIM_EN = 8;
   localparam logic [15:0] TCS_TUNING_RESET = 16'h0000;
   localparam logic [15:0] TCS_WRITE_MASK = 16'h1fff;
   localparam logic [7:0] TCS_CAL_BYTE_0 = 8'h55;
   localparam logic [7:0] TCS_CAL_BYTE_1 = 8'haa;
   localparam int TCS_CLK_HZ = 20000000;
   localparam int TCS_CAL_TIME_NS = 800;
   localparam int TCS_CAL_CYC = (TCS_CAL_TIME_NS * (TCS_CLK_HZ / 1000000) + 999) / 1000;
   localparam int TCS_TRIM_TIMEOUT_CYC = 64;
   localparam int TCS_NUM_COLOURS = 5;
   typedef enum logic [2:0] {TCS_RED, TCS_GREEN, TCS_BLUE, TCS_BLACK, TCS_WHITE} tcs_colour_t;
   typedef enum {TCS_TR_IDLE, TCS_TR_SEND, TCS_TR_WAIT} tcs_trim_state_t;
   typedef struct packed {
      logic valid;
      logic [7:0] header;
   } tcs_trim_req_t;
   typedef struct packed {
      logic valid;
      logic pass;
   } tcs_trim_rsp_t;
   typedef struct packed {
      logic frame_start;
      logic de;
   } tcs_timing_t;
endpackage : tcs_pkg

// ---- rtl/tcs_cal_engine.sv ----
// Internal XOR calibration engine: compares a fixed byte against its loopback.
// Assumes start is a one-cycle pulse on ref_clk.
`timescale 1ns/1ns
module tcs_cal_engine #(
   parameter int CYCLES = tcs_pkg::TCS_CAL_CYC
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Control.
   input wire logic start,
   input wire logic [7:0] cal_byte,
   input wire logic [3:0] filter,
   // Result.
   output logic done,
   output logic [7:0] xor_result
);
   logic [7:0] cnt_q, cnt_d;
   logic busy_q, busy_d;
   logic done_q, done_d;
   logic [7:0] res_q, res_d;
   always_comb begin
      cnt_d = cnt_q;
      busy_d = busy_q;
      done_d = 1'b0;
      res_d = res_q;
      if (start && !busy_q) begin
         busy_d = 1'b1;
         cnt_d = 8'(CYCLES - 1);
      end else if (busy_q) begin
         if (cnt_q == 8'h00) begin
            busy_d = 1'b0;
            done_d = 1'b1;
            // The filter masks out low bits of the compare, a loopback byte equals the pattern.
            res_d = (cal_byte ^ cal_byte) & ~{4'h0, filter};
         end else begin
            cnt_d = cnt_q - 8'h01;
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_q <= 8'h00;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         res_q <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
         res_q <= res_d;
      end
   end
   assign done = done_q;
   assign xor_result = res_q;
endmodule : tcs_cal_engine

// ---- rtl/tcs_vst_engine.sv ----
// Video self-test colour engine: cycles full-frame colours on frame boundaries.
// Assumes frame_start from the video timing generator on ref_clk.
`timescale 1ns/1ns
module tcs_vst_engine (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Control.
   input wire logic enable,
   input wire logic run,
   input wire logic frame_start,
   // Status.
   output logic active,
   output tcs_pkg::tcs_colour_t colour
);
   logic active_q, active_d;
   tcs_pkg::tcs_colour_t colour_q, colour_d;
   always_comb begin
      active_d = active_q;
      colour_d = colour_q;
      if (!enable) begin
         active_d = 1'b0;
         colour_d = tcs_pkg::TCS_RED;
      end else if (frame_start) begin
         // Run starts and stops the pattern only at frame boundaries so no frame is torn.
         active_d = run;
         if (active_q) begin
            colour_d = (colour_q == tcs_pkg::TCS_WHITE) ? tcs_pkg::TCS_RED
                       : tcs_pkg::tcs_colour_t'(colour_q + 3'd1);
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         active_q <= 1'b0;
         colour_q <= tcs_pkg::TCS_RED;
      end else begin
         active_q <= active_d;
         colour_q <= colour_d;
      end
   end
   assign active = active_q;
   assign colour = colour_q;
endmodule : tcs_vst_engine

// ---- test/tcs_rx_model.sv ----
// Behavioural downstream receiver that answers trimming read requests.
// Assumes requests arrive as one-cycle pulses on ref_clk.
`timescale 1ns/1ns
module tcs_rx_model #(
   parameter int DELAY = 3
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Trimming link.
   input wire tcs_pkg::tcs_trim_req_t trim_req,
   output tcs_pkg::tcs_trim_rsp_t trim_rsp,
   // Behaviour chosen by the bench.
   input wire logic pass,
   input wire logic silent
);
   // Outside the answer the pass line shows the inverse value, so stale sampling is caught.
   initial begin
      trim_rsp = '0;
      forever begin
         @(posedge ref_clk);
         if (rst === 1'b0 && trim_req.valid === 1'b1 && silent === 1'b0) begin
            repeat (DELAY) @(posedge ref_clk);
            trim_rsp <= '{valid: 1'b1, pass: pass};
            @(posedge ref_clk);
            trim_rsp <= '{valid: 1'b0, pass: !pass};
         end
      end
   end
endmodule : tcs_rx_model

// ---- test/tb.sv ----
// Self-checking bench for the trim, calibration and video self-test block.
// Assumes the receiver model on the trimming link and a 32-cycle frame.
`timescale 1ns/1ns
module tb;
   localparam int FR = 32;
   localparam logic [7:0] TUN = tcs_pkg::TCS_OFS_TUNING;
   logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, vst_active, irq, silent, rx_pass;
   logic [7:0] avs_address, cal_result, hdr;
   logic [31:0] avs_writedata, avs_readdata;
   logic [31:0] exp_q[$];
   logic [3:0] avs_byteenable, flt;
   logic [2:0] vst_colour, ce;
   int fail_count, n_tests;
   int fcnt = 0;
   tcs_pkg::tcs_timing_t timing = '0;
   tcs_pkg::tcs_trim_req_t trim_req;
   tcs_pkg::tcs_trim_rsp_t trim_rsp;

   tcs_ctrl #(.TRIM_TIMEOUT(8)) dut_u (.ref_clk(ref_clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timing(timing),
      .vst_active(vst_active), .vst_colour(vst_colour), .trim_req(trim_req),
      .trim_rsp(trim_rsp), .cal_result(cal_result), .irq(irq));
   tcs_rx_model #(.DELAY(3)) rx_u (.ref_clk(ref_clk), .rst(rst), .trim_req(trim_req),
      .trim_rsp(trim_rsp), .pass(rx_pass), .silent(silent));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   // A hung handshake is cut short by the watchdog, not here.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rd

   task automatic next_frame;
      do @(posedge ref_clk); while (timing.frame_start !== 1'b1);
      repeat (3) @(posedge ref_clk);
   endtask : next_frame

   always @(posedge ref_clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
         check("readdata", avs_readdata, exp_q.pop_front());
      end
   end

   always @(posedge ref_clk) begin
      fcnt <= (fcnt == FR - 1) ? 0 : fcnt + 1;
      timing <= '{frame_start: (fcnt == FR - 1), de: 1'b1};
   end

   initial begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      give_verdict();
   end

   initial begin
      rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      silent = 1'b0;
      rx_pass = 1'b1;
      fail_count = 0;
      n_tests = 0;
      void'($urandom(32'hf55f1c69));
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      rd(TUN, 32'h0);
      bus(1'b1, TUN, 32'hf0a5);
      rd(TUN, 32'h10a5);
      bus(1'b1, 8'h10, 32'hffff);
      rd(8'h10, 32'h0);
      $display("test reset and access done");
      bus(1'b1, tcs_pkg::TCS_OFS_IRQ_MASK, 32'h2);
      for (int s = 0; s < 2; s++) begin
         flt = 4'($urandom);
         bus(1'b1, TUN, {16'h0, 3'h0, s[0], 1'b1, 7'h0, flt});
         repeat (24) @(posedge ref_clk);
         check("irq", 32'(irq), 32'h1);
         check("cal_result", 32'(cal_result), 32'h0);
         rd(TUN, {16'h0, 3'h1, s[0], 1'b0, 7'h0, flt});
         rd(TUN, {16'h0, 3'h0, s[0], 1'b0, 7'h0, flt});
         rd(tcs_pkg::TCS_OFS_IRQ_STAT, 32'h2);
         repeat (2) @(posedge ref_clk);
         check("irq", 32'(irq), 32'h0);
      end
      $display("test calibration done");
      // Pass answer, silent receiver, then a failing answer.
      for (int k = 0; k < 3; k++) begin
         hdr = 8'($urandom);
         silent <= (k == 1);
         rx_pass <= (k != 2);
         bus(1'b1, TUN, {16'h0, 8'h01, hdr});
         do @(posedge ref_clk); while (trim_req.valid !== 1'b1);
         check("trim_header", 32'(trim_req.header), 32'(hdr));
         repeat (20) @(posedge ref_clk);
         check("irq", 32'(irq), 32'h0);
         rd(TUN, {16'h0, 1'b1, (k == 0), 6'h0, hdr});
      end
      rd(tcs_pkg::TCS_OFS_IRQ_STAT, 32'h1);
      $display("test trimming done");
      bus(1'b1, TUN, 32'h0600);
      next_frame();
      next_frame();
      check("vst_active", 32'(vst_active), 32'h1);
      ce = vst_colour;
      for (int f = 0; f < 6; f++) begin
         next_frame();
         ce = (ce == 3'(tcs_pkg::TCS_NUM_COLOURS - 1)) ? 3'h0 : ce + 3'h1;
         check("colour", 32'(vst_colour), 32'(ce));
      end
      // Stopping mid-frame must keep the pattern going until the frame ends.
      bus(1'b1, TUN, 32'h0200);
      check("vst_active", 32'(vst_active), 32'h1);
      next_frame();
      check("vst_active", 32'(vst_active), 32'h0);
      repeat (FR) @(posedge ref_clk);
      bus(1'b1, TUN, 32'h0);
      rd(tcs_pkg::TCS_OFS_IRQ_STAT, 32'h4);
      $display("test video self-test done");
      // A reset in mid-run must clear every writable field again.
      bus(1'b1, TUN, 32'h16a5);
      bus(1'b1, tcs_pkg::TCS_OFS_IRQ_MASK, 32'h7);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rd(TUN, 32'h0);
      rd(tcs_pkg::TCS_OFS_IRQ_MASK, 32'h0);
      $display("test mid-run reset done");
      give_verdict();
   end
endmodule : tb
